//--- src/wptps_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Ping phase drives power and waits for a genuine receiver response.
// - Good signal strength packet in ping moves to identification, power kept on.
// - Configuration packet accepted, default contract is set up.
// - Every negotiation request gets a grant or a deny answer, unless a quality factor mismatch arrives in the same cycle.
// - Quality factor mismatch in negotiation returns to selection.
// - Calibration runs light load mode then heavy load mode.
// - Power transfer starts once a contract exists.
// - Control error packets adjust delivered power level.
// - Received power reports feed the foreign object check.
// - End transfer packet terminates power transfer.
// - Active-low enable high puts the device into shutdown.
// - Supply below lockout threshold shuts the system down.
// - Lockout threshold follows adaptor voltage and is configurable.
// - Die over 140 C shuts down, resumes below 120 C.
// - Thermistor voltage compared to configurable threshold with default.
// - Low thermistor voltage halts power and flags system error.
// - Idle transmitter stays in standby pinging periodically.
// - Selection uses low-level measurement signal to watch the surface.
module wptps_top
   import wptps_pkg::*;
#(
   parameter int PING_CNT = PING_CYCLES
) (
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   input wire logic I_ENABLE_N,
   input wire logic [11:0] I_VIN_LEVEL,
   input wire logic [11:0] I_THERM_LEVEL,
   input wire logic [7:0] I_DIE_TEMP,
   input wire logic I_OBJECT_SEEN,
   input wire logic I_PKT_VALID,
   input wire logic [2:0] I_PKT_KIND,
   input wire logic [7:0] I_PKT_DATA,
   input wire logic I_Q_MISMATCH,
   input wire logic I_POWER_MISMATCH,
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic O_POWER_ON,
   output logic O_MEASURE_ON,
   output logic [11:0] O_POWER_LEVEL,
   output logic O_FSK_ACK,
   output logic O_FSK_NAK,
   output logic O_SHUTDOWN,
   output logic [6:0] O_PHASE
);
   if (PING_CNT < 2 || PING_CNT > 65535) begin : g_bad_ping
      $error("PING_CNT out of range");
   end

   typedef struct packed {
      wptps_phase_e phase;
      logic [15:0] ping_cnt;
      logic cal_mode2;
      logic contract;
      logic [3:0] ctrl;
      logic [11:0] input_undervoltage_lockout_lo;
      logic [11:0] input_undervoltage_lockout_hi;
      logic [11:0] therm_th;
      logic [3:0] sys_err;
      logic [11:0] power;
      logic power_on;
      logic measure_on;
      logic fsk_ack;
      logic fsk_nak;
      logic shutdown;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } wptps_top_s;

   wptps_top_s s_r;
   wptps_top_s s_nxt;
   wptps_prot_if pif();

   // Any fault source forcing shutdown
   function automatic logic any_fault(input logic en_n, input logic u, input logic d, input logic t);
      any_fault = en_n | u | d | t;
   endfunction : any_fault

   // Saturating signed adjust of the power level
   function automatic logic [11:0] adj_power(input logic [11:0] cur, input logic [7:0] err);
      logic signed [13:0] sum;
      sum = $signed({2'b00, cur}) + $signed({{6{err[7]}}, err});
      if (sum < 0) begin
         adj_power = 12'h000;
      end else if (sum > 14'sd4095) begin
         adj_power = 12'hfff;
      end else begin
         adj_power = sum[11:0];
      end
   endfunction : adj_power

   assign pif.vin = I_VIN_LEVEL;
   assign pif.therm = I_THERM_LEVEL;
   assign pif.die_temp = I_DIE_TEMP;
   assign pif.input_undervoltage_lockout_lo = s_r.input_undervoltage_lockout_lo;
   assign pif.input_undervoltage_lockout_hi = s_r.input_undervoltage_lockout_hi;
   assign pif.therm_th = s_r.therm_th;
   assign pif.hi_adapt = s_r.ctrl[CTRL_HI_ADAPT_BIT];

   wptps_protect u_prot (
      .i_clk(I_REF_CLK),
      .i_rst(I_RESET),
      .p(pif.prot)
   );

   logic fault;
   assign fault = any_fault(I_ENABLE_N, pif.input_undervoltage_lockout_flt, pif.die_flt, pif.therm_flt);

   // Next-state: phase sequencer and register slave
   always_comb begin
      s_nxt = s_r;
      s_nxt.fsk_ack = 1'b0;
      s_nxt.fsk_nak = 1'b0;
      // Sticky error flags, set wins over software clear
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid && s_r.aw_addr == OFF_SYS_ERR && s_r.w_data[0 +: 1] != 1'b0) begin
         s_nxt.sys_err = s_r.sys_err & ~s_r.w_data[3:0];
      end
      if (pif.therm_flt) s_nxt.sys_err[ERR_THERM_BIT] = 1'b1;
      if (pif.input_undervoltage_lockout_flt) s_nxt.sys_err[ERR_INPUT_UNDERVOLTAGE_LOCKOUT_BIT] = 1'b1;
      if (pif.die_flt) s_nxt.sys_err[ERR_DIE_BIT] = 1'b1;
      if (fault) begin
         s_nxt.phase = PH_SHUT;
         s_nxt.contract = 1'b0;
      end else begin
         case (s_r.phase)
            PH_SHUT: begin
               s_nxt.phase = PH_SELECT;
               s_nxt.ping_cnt = '0;
            end
            PH_SELECT: begin
               // Count up to the next periodic ping
               s_nxt.ping_cnt = s_r.ping_cnt + 16'h0001;
               if (I_OBJECT_SEEN || s_r.ping_cnt == 16'(PING_CNT - 1)) begin
                  s_nxt.phase = PH_PING;
                  s_nxt.ping_cnt = '0;
               end
            end
            PH_PING: begin
               s_nxt.ping_cnt = s_r.ping_cnt + 16'h0001;
               if (I_PKT_VALID && I_PKT_KIND == PKT_SIG_STRENGTH) begin
                  s_nxt.phase = PH_IDCFG;
               end else if (s_r.ping_cnt == 16'(PING_CNT - 1)) begin
                  s_nxt.phase = PH_SELECT;
                  s_nxt.ping_cnt = '0;
               end
            end
            PH_IDCFG: begin
               if (I_PKT_VALID && I_PKT_KIND == PKT_CONFIG) begin
                  s_nxt.contract = 1'b1;
                  s_nxt.power = POWER_RST;
                  s_nxt.cal_mode2 = 1'b0;
                  // Silence answers as a baseline transmitter
                  if (s_r.ctrl[CTRL_EXT_PROF_BIT]) begin
                     s_nxt.fsk_ack = 1'b1;
                     s_nxt.phase = PH_NEGOT;
                  end else begin
                     s_nxt.phase = PH_XFER;
                  end
               end
            end
            PH_NEGOT: begin
               if (I_Q_MISMATCH) begin
                  s_nxt.phase = PH_SELECT;
                  s_nxt.sys_err[ERR_FOREIGN_BIT] = 1'b1;
                  s_nxt.contract = 1'b0;
                  s_nxt.ping_cnt = '0;
               end else if (I_PKT_VALID && I_PKT_KIND == PKT_NEG_REQ) begin
                  s_nxt.fsk_ack = s_r.ctrl[CTRL_GRANT_BIT];
                  s_nxt.fsk_nak = !s_r.ctrl[CTRL_GRANT_BIT];
               end else if (I_PKT_VALID && I_PKT_KIND == PKT_CAL) begin
                  s_nxt.phase = PH_CALIB;
               end
            end
            PH_CALIB: begin
               if (I_PKT_VALID && I_PKT_KIND == PKT_CAL && s_r.ctrl[CTRL_ACK_CAL_BIT]) begin
                  s_nxt.fsk_ack = 1'b1;
                  s_nxt.cal_mode2 = 1'b1;
                  if (s_r.cal_mode2) s_nxt.phase = PH_XFER;
               end
            end
            PH_XFER: begin
               if (I_PKT_VALID && I_PKT_KIND == PKT_CTRL_ERR) begin
                  s_nxt.power = adj_power(s_r.power, I_PKT_DATA);
               end else if (I_PKT_VALID && I_PKT_KIND == PKT_RX_POWER && I_POWER_MISMATCH) begin
                  s_nxt.phase = PH_SELECT;
                  s_nxt.sys_err[ERR_FOREIGN_BIT] = 1'b1;
                  s_nxt.contract = 1'b0;
                  s_nxt.ping_cnt = '0;
               end else if (I_PKT_VALID && I_PKT_KIND == PKT_END) begin
                  s_nxt.phase = PH_SELECT;
                  s_nxt.contract = 1'b0;
                  s_nxt.ping_cnt = '0;
               end
            end
            default: s_nxt.phase = PH_SHUT;
         endcase
      end
      s_nxt.shutdown = (s_nxt.phase == PH_SHUT);
      s_nxt.power_on = s_nxt.phase inside {PH_PING, PH_IDCFG, PH_NEGOT, PH_CALIB, PH_XFER};
      s_nxt.measure_on = (s_nxt.phase == PH_SELECT);
      // AXI write channel
      s_nxt.awready = 1'b0;
      s_nxt.wready = 1'b0;
      if (S_AXI_AWVALID && !s_r.aw_got && !s_r.awready) begin
         s_nxt.awready = 1'b1;
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = S_AXI_AWADDR[7:0];
      end
      if (S_AXI_WVALID && !s_r.w_got && !s_r.wready) begin
         s_nxt.wready = 1'b1;
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = S_AXI_WDATA;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = 2'b00;
         case (s_r.aw_addr)
            OFF_CTRL: s_nxt.ctrl = s_r.w_data[3:0];
            OFF_INPUT_UNDERVOLTAGE_LOCKOUT_LO: s_nxt.input_undervoltage_lockout_lo = s_r.w_data[11:0];
            OFF_INPUT_UNDERVOLTAGE_LOCKOUT_HI: s_nxt.input_undervoltage_lockout_hi = s_r.w_data[11:0];
            OFF_THERM_TH: s_nxt.therm_th = s_r.w_data[11:0];
            OFF_SYS_ERR, OFF_STATUS, OFF_POWER: s_nxt.bresp = 2'b00;
            default: s_nxt.bresp = 2'b10;
         endcase
      end
      if (s_r.bvalid && S_AXI_BREADY) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
      end
      // AXI read channel
      s_nxt.arready = 1'b0;
      if (S_AXI_ARVALID && !s_r.rvalid && !s_r.arready) begin
         s_nxt.arready = 1'b1;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = 2'b00;
         case (S_AXI_ARADDR[7:0])
            OFF_CTRL: s_nxt.rdata = {28'h0000000, s_r.ctrl};
            OFF_STATUS: s_nxt.rdata = {24'h000000, s_r.contract, s_r.phase};
            OFF_INPUT_UNDERVOLTAGE_LOCKOUT_LO: s_nxt.rdata = {20'h00000, s_r.input_undervoltage_lockout_lo};
            OFF_INPUT_UNDERVOLTAGE_LOCKOUT_HI: s_nxt.rdata = {20'h00000, s_r.input_undervoltage_lockout_hi};
            OFF_THERM_TH: s_nxt.rdata = {20'h00000, s_r.therm_th};
            OFF_SYS_ERR: s_nxt.rdata = {28'h0000000, s_r.sys_err};
            OFF_POWER: s_nxt.rdata = {20'h00000, s_r.power};
            default: begin
               s_nxt.rdata = 32'h00000000;
               s_nxt.rresp = 2'b10;
            end
         endcase
      end else if (s_r.rvalid && S_AXI_RREADY) begin
         s_nxt.rvalid = 1'b0;
      end
   end

   // State register
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         s_r <= '0;
         s_r.phase <= PH_SHUT;
         s_r.shutdown <= 1'b1;
         s_r.input_undervoltage_lockout_lo <= INPUT_UNDERVOLTAGE_LOCKOUT_LO_RST;
         s_r.input_undervoltage_lockout_hi <= INPUT_UNDERVOLTAGE_LOCKOUT_HI_RST;
         s_r.therm_th <= THERM_TH_RST;
         s_r.power <= POWER_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign S_AXI_AWREADY = s_r.awready;
   assign S_AXI_WREADY = s_r.wready;
   assign S_AXI_BVALID = s_r.bvalid;
   assign S_AXI_BRESP = s_r.bresp;
   assign S_AXI_ARREADY = s_r.arready;
   assign S_AXI_RVALID = s_r.rvalid;
   assign S_AXI_RDATA = s_r.rdata;
   assign S_AXI_RRESP = s_r.rresp;
   assign O_POWER_ON = s_r.power_on;
   assign O_MEASURE_ON = s_r.measure_on;
   assign O_POWER_LEVEL = s_r.power;
   assign O_FSK_ACK = s_r.fsk_ack;
   assign O_FSK_NAK = s_r.fsk_nak;
   assign O_SHUTDOWN = s_r.shutdown;
   assign O_PHASE = s_r.phase;

   a_enable_shut: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_ENABLE_N |=> (O_SHUTDOWN && !O_POWER_ON)) else $error("disable did not shut down");
   a_ping_to_id: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      (s_r.phase == PH_PING && I_PKT_VALID && I_PKT_KIND == PKT_SIG_STRENGTH && !fault)
      |=> (s_r.phase == PH_IDCFG && O_POWER_ON)) else $error("ping did not advance");
   a_neg_answer: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      (s_r.phase == PH_NEGOT && I_PKT_VALID && I_PKT_KIND == PKT_NEG_REQ && !fault && !I_Q_MISMATCH)
      |=> (O_FSK_ACK ^ O_FSK_NAK)) else $error("negotiation request unanswered");
   a_q_select: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      (s_r.phase == PH_NEGOT && I_Q_MISMATCH && !fault) |=> (s_r.phase == PH_SELECT)) else
      $error("foreign object not handled");
   a_cal_hold: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      (s_r.phase == PH_CALIB && !s_r.ctrl[CTRL_ACK_CAL_BIT] && !fault) |=> $stable(s_r.cal_mode2)) else
      $error("calibration advanced without ack");
   a_end_xfer: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      (s_r.phase == PH_XFER && I_PKT_VALID && I_PKT_KIND == PKT_END && !fault)
      |=> (!O_POWER_ON && s_r.phase == PH_SELECT)) else $error("end packet ignored");
   a_therm_flag: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      pif.therm_flt |=> (s_r.sys_err[ERR_THERM_BIT] && s_r.phase == PH_SHUT)) else
      $error("thermistor flag missing");
   a_shut_return: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      (s_r.phase == PH_SHUT && !fault) |=> (s_r.phase == PH_SELECT && O_MEASURE_ON && !O_POWER_ON)) else
      $error("no return to selection");
   a_phase_seen: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      (s_r.phase == PH_SELECT && I_OBJECT_SEEN && !fault) |=> (O_PHASE == PH_PING)) else
      $error("phase not visible");
endmodule : wptps_top

//--- common/wptps_pkg.sv
package wptps_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_INPUT_UNDERVOLTAGE_LOCKOUT_LO = 8'h08;
   localparam logic [7:0] OFF_INPUT_UNDERVOLTAGE_LOCKOUT_HI = 8'h0c;
   localparam logic [7:0] OFF_THERM_TH = 8'h10;
   localparam logic [7:0] OFF_SYS_ERR = 8'h14;
   localparam logic [7:0] OFF_POWER = 8'h18;
   // Control fields
   localparam int CTRL_GRANT_BIT = 0;
   localparam int CTRL_ACK_CAL_BIT = 1;
   localparam int CTRL_EXT_PROF_BIT = 2;
   localparam int CTRL_HI_ADAPT_BIT = 3;
   // System error fields
   localparam int ERR_THERM_BIT = 0;
   localparam int ERR_INPUT_UNDERVOLTAGE_LOCKOUT_BIT = 1;
   localparam int ERR_DIE_BIT = 2;
   localparam int ERR_FOREIGN_BIT = 3;
   // Reset values
   localparam logic [11:0] INPUT_UNDERVOLTAGE_LOCKOUT_LO_RST = 12'h200;
   localparam logic [11:0] INPUT_UNDERVOLTAGE_LOCKOUT_HI_RST = 12'h600;
   localparam logic [11:0] THERM_TH_RST = 12'h300;
   localparam logic [11:0] POWER_RST = 12'h080;
   // Die temperature limits in degrees C
   localparam logic [7:0] DIE_HOT_C = 8'h8c;
   localparam logic [7:0] DIE_COOL_C = 8'h78;
   // Ping repeat interval
   localparam int PING_PERIOD_US = 500;
   localparam int CLK_MHZ = 40;
   localparam int PING_CYCLES = PING_PERIOD_US * CLK_MHZ;
   // Packet kinds from the receiver
   localparam logic [2:0] PKT_SIG_STRENGTH = 3'h1;
   localparam logic [2:0] PKT_CONFIG = 3'h2;
   localparam logic [2:0] PKT_NEG_REQ = 3'h3;
   localparam logic [2:0] PKT_CAL = 3'h4;
   localparam logic [2:0] PKT_CTRL_ERR = 3'h5;
   localparam logic [2:0] PKT_RX_POWER = 3'h6;
   localparam logic [2:0] PKT_END = 3'h7;
   // Phases, one-hot
   typedef enum logic [6:0] {
      PH_SELECT = 7'h01,
      PH_PING = 7'h02,
      PH_IDCFG = 7'h04,
      PH_NEGOT = 7'h08,
      PH_CALIB = 7'h10,
      PH_XFER = 7'h20,
      PH_SHUT = 7'h40
   } wptps_phase_e;
endpackage : wptps_pkg

//--- common/wptps_prot_if.sv
`timescale 1ns/1ps
interface wptps_prot_if;
   logic [11:0] vin;
   logic [11:0] therm;
   logic [7:0] die_temp;
   logic [11:0] input_undervoltage_lockout_lo;
   logic [11:0] input_undervoltage_lockout_hi;
   logic [11:0] therm_th;
   logic hi_adapt;
   logic input_undervoltage_lockout_flt;
   logic die_flt;
   logic therm_flt;
   modport prot (input vin, therm, die_temp, input_undervoltage_lockout_lo, input_undervoltage_lockout_hi, therm_th, hi_adapt,
                 output input_undervoltage_lockout_flt, die_flt, therm_flt);
   modport ctl (output vin, therm, die_temp, input_undervoltage_lockout_lo, input_undervoltage_lockout_hi, therm_th, hi_adapt,
                input input_undervoltage_lockout_flt, die_flt, therm_flt);
endinterface : wptps_prot_if

//--- src/wptps_protect.sv
`timescale 1ns/1ps
module wptps_protect
   import wptps_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   wptps_prot_if.prot p
);
   typedef struct packed {
      logic input_undervoltage_lockout;
      logic die;
      logic therm;
   } wptps_prot_s;
   wptps_prot_s st_r;
   wptps_prot_s st_nxt;

   // Fault evaluation; die fault has hysteresis
   always_comb begin
      st_nxt = st_r;
      st_nxt.input_undervoltage_lockout = p.vin < (p.hi_adapt ? p.input_undervoltage_lockout_hi : p.input_undervoltage_lockout_lo);
      st_nxt.therm = p.therm < p.therm_th;
      if (p.die_temp > DIE_HOT_C) begin
         st_nxt.die = 1'b1;
      end else if (p.die_temp < DIE_COOL_C) begin
         st_nxt.die = 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign p.input_undervoltage_lockout_flt = st_r.input_undervoltage_lockout;
   assign p.die_flt = st_r.die;
   assign p.therm_flt = st_r.therm;

   a_die_hyst: assert property (@(posedge i_clk) disable iff (i_rst)
      (st_r.die && p.die_temp >= DIE_COOL_C) |=> st_r.die) else $error("die fault released early");
   a_therm_trip: assert property (@(posedge i_clk) disable iff (i_rst)
      (p.therm < p.therm_th) |=> st_r.therm) else $error("thermistor fault missed");
endmodule : wptps_protect

//--- verif/wptps_rx_model.sv
`timescale 1ns/1ps
module wptps_rx_model
   import wptps_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_fsk_ack,
   input wire logic i_fsk_nak,
   output logic o_pkt_valid,
   output logic [2:0] o_pkt_kind,
   output logic [7:0] o_pkt_data
);
   logic baseline_profile = 1'b0;
   logic [1:0] cal_mode = 2'h0;
   logic got_ack = 1'b0;
   logic got_nak = 1'b0;
   // Packet lines idle low until the first packet
   initial begin
      o_pkt_valid = 1'b0;
      o_pkt_kind = 3'h0;
      o_pkt_data = 8'h00;
   end
   // One decoded packet after dly idle cycles; fields scrambled once released
   task automatic send(input logic [2:0] kind, input logic [7:0] data, input int dly);
      repeat (dly) @(posedge i_clk);
      o_pkt_valid <= 1'b1;
      o_pkt_kind <= kind;
      o_pkt_data <= data;
      @(posedge i_clk);
      o_pkt_valid <= 1'b0;
      o_pkt_kind <= ~kind;
      o_pkt_data <= ~data;
      @(posedge i_clk);
      got_ack = i_fsk_ack;
      got_nak = i_fsk_nak;
      // Silent answer to configuration means a baseline transmitter
      if (kind == PKT_CONFIG) baseline_profile = !got_ack;
      // Calibration mode advances only when acknowledged
      if (kind == PKT_CAL && got_ack) cal_mode = cal_mode + 2'h1;
   endtask : send
endmodule : wptps_rx_model

//--- verif/wptps_top_tb.sv
`timescale 1ns/1ps
module wptps_top_tb;
   import wptps_pkg::*;
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en_n = 1'b0;
   logic [11:0] vin = 12'h800;
   logic [11:0] therm = 12'hfff;
   logic [7:0] die = 8'h19;
   logic obj = 1'b0;
   logic qmm = 1'b0;
   logic pmm = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pkt_v, pwr, meas, ack, nak, shut;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic [2:0] pkt_k;
   logic [7:0] pkt_d;
   logic [11:0] lvl;
   logic [6:0] phase;
   int mismatches = 0, checked = 0, cycles = 0;

   wptps_top #(.PING_CNT(16)) wptps_top_inst (
      .I_REF_CLK(clk), .I_RESET(rst), .I_ENABLE_N(en_n), .I_VIN_LEVEL(vin), .I_THERM_LEVEL(therm),
      .I_DIE_TEMP(die), .I_OBJECT_SEEN(obj), .I_PKT_VALID(pkt_v), .I_PKT_KIND(pkt_k), .I_PKT_DATA(pkt_d),
      .I_Q_MISMATCH(qmm), .I_POWER_MISMATCH(pmm), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .O_POWER_ON(pwr),
      .O_MEASURE_ON(meas), .O_POWER_LEVEL(lvl), .O_FSK_ACK(ack), .O_FSK_NAK(nak), .O_SHUTDOWN(shut),
      .O_PHASE(phase));

   wptps_rx_model wptps_rx_model_inst (.i_clk(clk), .i_fsk_ack(ack), .i_fsk_nak(nak),
      .o_pkt_valid(pkt_v), .o_pkt_kind(pkt_k), .o_pkt_data(pkt_d));

   // Free running 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches = mismatches + 1;
         end_sim();
      end
   end

   task automatic end_sim();
      if (mismatches == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Write one word; address and data released each at its own ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clk);
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr

   // Read one word into rd and its response into rsp
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rd_reg

   task automatic wait_ph(input logic [6:0] p);
      int n;
      n = 0;
      while (phase !== p && n < 64) begin
         @(posedge clk);
         n = n + 1;
      end
      chk(32'(phase), 32'(p));
   endtask : wait_ph

   task automatic pkt(input logic [2:0] k, input logic [7:0] d);
      wptps_rx_model_inst.send(k, d, 1);
   endtask : pkt

   // Object placed, ping, signal strength, configuration
   task automatic link(input logic [31:0] ctrl);
      wr(OFF_CTRL, ctrl);
      wait_ph(PH_SELECT);
      obj <= 1'b1;
      wait_ph(PH_PING);
      chk(32'(pwr), 32'h1);
      obj <= 1'b0;
      pkt(PKT_SIG_STRENGTH, 8'h80);
      wait_ph(PH_IDCFG);
      chk(32'(pwr), 32'h1);
      pkt(PKT_CONFIG, 8'h00);
   endtask : link

   task automatic t_reset();
      wait_ph(PH_SELECT);
      repeat (2) @(posedge clk);
      chk(32'(meas), 32'h1);
      chk(32'(pwr), 32'h0);
      rd_reg(OFF_INPUT_UNDERVOLTAGE_LOCKOUT_LO);
      chk(rd, 32'(INPUT_UNDERVOLTAGE_LOCKOUT_LO_RST));
      rd_reg(OFF_INPUT_UNDERVOLTAGE_LOCKOUT_HI);
      chk(rd, 32'(INPUT_UNDERVOLTAGE_LOCKOUT_HI_RST));
      rd_reg(OFF_THERM_TH);
      chk(rd, 32'(THERM_TH_RST));
      rd_reg(OFF_STATUS);
      chk(32'(rd[6:0]), 32'(PH_SELECT));
      rd_reg(8'h1c);
      chk(32'(rsp), 32'h2);
      wr(8'h1c, 32'h1);
      chk(32'(rsp), 32'h2);
   endtask : t_reset

   // Baseline path: silent configuration, control error, power mismatch
   task automatic t_base();
      link(32'h0);
      chk(32'(wptps_rx_model_inst.baseline_profile), 32'h1);
      wait_ph(PH_XFER);
      pkt(PKT_CTRL_ERR, 8'h20);
      repeat (2) @(posedge clk);
      chk(32'(lvl), 32'(POWER_RST) + 32'h20);
      pmm <= 1'b1;
      pkt(PKT_RX_POWER, 8'h40);
      wait_ph(PH_SELECT);
      pmm <= 1'b0;
      obj <= 1'b1;
      wait_ph(PH_PING);
      obj <= 1'b0;
      wait_ph(PH_SELECT);
   endtask : t_base

   // Extended path: grant, deny, calibration held, end packet
   task automatic t_ext();
      link(32'h5);
      chk(32'(wptps_rx_model_inst.got_ack), 32'h1);
      wait_ph(PH_NEGOT);
      pkt(PKT_NEG_REQ, 8'h01);
      chk(32'(wptps_rx_model_inst.got_ack), 32'h1);
      wr(OFF_CTRL, 32'h4);
      pkt(PKT_NEG_REQ, 8'h02);
      chk(32'(wptps_rx_model_inst.got_nak), 32'h1);
      pkt(PKT_CAL, 8'h00);
      wait_ph(PH_CALIB);
      pkt(PKT_CAL, 8'h00);
      chk(32'(wptps_rx_model_inst.got_ack), 32'h0);
      wait_ph(PH_CALIB);
      wr(OFF_CTRL, 32'h6);
      pkt(PKT_CAL, 8'h00);
      chk(32'(wptps_rx_model_inst.got_ack), 32'h1);
      pkt(PKT_CAL, 8'h01);
      wait_ph(PH_XFER);
      chk(32'(wptps_rx_model_inst.cal_mode), 32'h2);
      pkt(PKT_END, 8'h00);
      wait_ph(PH_SELECT);
      link(32'h5);
      wait_ph(PH_NEGOT);
      qmm <= 1'b1;
      wait_ph(PH_SELECT);
      qmm <= 1'b0;
   endtask : t_ext

   // Disable, lockout, die and thermistor faults with their limits
   task automatic t_fault();
      en_n <= 1'b1;
      wait_ph(PH_SHUT);
      chk(32'(shut), 32'h1);
      en_n <= 1'b0;
      wait_ph(PH_SELECT);
      vin <= 12'h1ff;
      wait_ph(PH_SHUT);
      vin <= 12'h5ff;
      wait_ph(PH_SELECT);
      wr(OFF_CTRL, 32'h8);
      wait_ph(PH_SHUT);
      vin <= 12'h600;
      wait_ph(PH_SELECT);
      die <= 8'h8c;
      repeat (8) @(posedge clk);
      chk(32'(phase), 32'(PH_SELECT));
      die <= 8'h8d;
      wait_ph(PH_SHUT);
      die <= 8'h78;
      repeat (8) @(posedge clk);
      chk(32'(phase), 32'(PH_SHUT));
      die <= 8'h77;
      wait_ph(PH_SELECT);
      link(32'h0);
      wait_ph(PH_XFER);
      therm <= 12'h2ff;
      wait_ph(PH_SHUT);
      chk(32'(pwr), 32'h0);
      therm <= 12'h300;
      wait_ph(PH_SELECT);
      rd_reg(OFF_SYS_ERR);
      chk(32'(rd[3:0]), 32'hf);
      wr(OFF_SYS_ERR, 32'hf);
      rd_reg(OFF_SYS_ERR);
      chk(rd, 32'h0);
   endtask : t_fault

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_base();
      t_ext();
      t_fault();
      end_sim();
   end
endmodule : wptps_top_tb
